// ---- common/eeprom_pkg.sv ----
// Purpose: Shared constants and types for the two-wire serial memory slave.
// Assumes: System clock of 100 MHz.
// Notes:   Write cycle time is a plain default; shorten it through the top parameter.
package eeprom_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_TIME_NS = 5000000;
  localparam int WRITE_CYCLES_DEF = WRITE_TIME_NS / CLK_PERIOD_NS;

  // ****************************************
  // Addressing and framing
  // ****************************************
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  localparam int ADDR_W_DEF = 11;
  localparam int PAGE_BITS_DEF = 4;
  localparam int PAGE_DEPTH_DEF = 16;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // ****************************************
  // Link states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_WADDR,
    ST_WDATA,
    ST_RDATA,
    ST_WAIT
  } link_state_t;

endpackage

// ---- rtl/page_fifo.sv ----
// Purpose: Synchronous FIFO holding address and data of bytes awaiting programming.
// Assumes: One clock; push and pop may happen in the same cycle.
// Notes:   Show-ahead output; full and empty are exact.
module page_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_q [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PW:0] cnt_q, cnt_d;
  logic push, pop;

  // Handshake and pointer updates
  always_comb begin
    in_ready = (cnt_q != (PW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    wr_d = push ? ((wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d = pop ? ((rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    out_data = store_q[rd_q];
  end

  // Pointer registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      store_q[wr_q] <= in_data;
    end
  end

endmodule

// ---- rtl/serial_eeprom.sv ----
// Purpose: Two-wire bus slave of a small byte-wide nonvolatile memory.
// Assumes: Link clock and data are sampled by clk through two flip-flops.
// Notes:   Received bytes wait in a FIFO and are programmed after the stop.
module serial_eeprom
  import eeprom_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int PAGE_BITS = PAGE_BITS_DEF,
  parameter int PAGE_DEPTH = PAGE_DEPTH_DEF,
  parameter bit WRAP_EN = (ADDR_W > 7),
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic wp_i,
  input wire logic [2:0] a_i,
  output logic prog_busy
);

  // ****************************************
  // Derived constants
  // ****************************************
  localparam int HI = (ADDR_W > 8) ? ADDR_W - 8 : 0;
  localparam logic [2:0] CS_MASK = 3'(3'h7 << HI);
  localparam int FW = ADDR_W + 8;
  localparam logic [ADDR_W-1:0] TOP_ADDR = '1;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3, wp_s1, wp_s2;
  logic [2:0] a_s1, a_s2;

  // Two flops per pin, third stage for edge finding
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      wp_s1 <= 1'b0;
      wp_s2 <= 1'b0;
      a_s1 <= 3'h0;
      a_s2 <= 3'h0;
    end else begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      wp_s1 <= wp_i;
      wp_s2 <= wp_s1;
      a_s1 <= a_i;
      a_s2 <= a_s1;
    end
  end

  logic scl_rise, scl_fall, start_cond, stop_cond;

  // Bus events
  always_comb begin
    scl_rise = scl_s2 & ~scl_s3;
    scl_fall = ~scl_s2 & scl_s3;
    start_cond = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    stop_cond = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  end

  // ****************************************
  // Array and page FIFO
  // ****************************************
  logic [7:0] mem_q [2**ADDR_W];
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid;
  logic [FW-1:0] fifo_in_data, fifo_out_data;
  logic busy_q, busy_d;
  logic [31:0] timer_q, timer_d;

  page_fifo #(
    .WIDTH(FW),
    .DEPTH(PAGE_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(busy_q),
    .out_data(fifo_out_data)
  );

  // Programming drains the FIFO only while busy
  always_ff @(posedge clk) begin
    if (busy_q && fifo_out_valid) begin
      mem_q[fifo_out_data[FW-1:8]] <= fifo_out_data[7:0];
    end
  end

  // ****************************************
  // Link state
  // ****************************************
  link_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic in_ack_q, in_ack_d, oe_q, oe_d, rnw_q, rnw_d, mack_q, mack_d;
  logic wrote_q, wrote_d;
  logic [7:0] shreg_q, shreg_d;
  logic [2:0] dev_q, dev_d;
  logic [ADDR_W-1:0] ptr_q, ptr_d, ptr_inc;
  logic [10:0] addr_full;
  logic dev_match, ack_now;

  // Next state of the serial engine
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    in_ack_d = in_ack_q;
    oe_d = oe_q;
    rnw_d = rnw_q;
    mack_d = mack_q;
    wrote_d = wrote_q;
    shreg_d = shreg_q;
    dev_d = dev_q;
    ptr_d = ptr_q;
    fifo_in_valid = 1'b0;
    ack_now = 1'b0;
    addr_full = {dev_q, shreg_q};
    fifo_in_data = {ptr_q, shreg_q};
    dev_match = (shreg_q[7:4] == DEV_TYPE_CODE) &&
                (((shreg_q[3:1] ^ a_s2) & CS_MASK) == 3'h0);
    // Full-width increment with optional hold at the top
    if (!WRAP_EN && ptr_q == TOP_ADDR) begin
      ptr_inc = ptr_q;
    end else begin
      ptr_inc = ptr_q + 1'b1;
    end
    if (start_cond) begin
      state_d = ST_DEV;
      cnt_d = 4'h0;
      in_ack_d = 1'b0;
      oe_d = 1'b0;
    end else if (stop_cond) begin
      state_d = ST_IDLE;
      oe_d = 1'b0;
      in_ack_d = 1'b0;
      wrote_d = 1'b0;
    end else begin
      case (state_q)
        ST_DEV, ST_WADDR, ST_WDATA: begin
          if (scl_rise && cnt_q < ACK_SLOT) begin
            shreg_d = {shreg_q[6:0], sda_s2};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == ACK_SLOT && !in_ack_q) begin
            if (state_q == ST_DEV) begin
              ack_now = dev_match & ~busy_q;
              rnw_d = shreg_q[0];
              dev_d = shreg_q[3:1];
            end else if (state_q == ST_WADDR) begin
              ack_now = 1'b1;
              ptr_d = addr_full[ADDR_W-1:0];
            end else begin
              ack_now = ~wp_s2 & fifo_in_ready;
              fifo_in_valid = ack_now;
              if (ack_now) begin
                wrote_d = 1'b1;
                ptr_d = {ptr_q[ADDR_W-1:PAGE_BITS], ptr_q[PAGE_BITS-1:0] + 1'b1};
              end
            end
            in_ack_d = ack_now;
            oe_d = ack_now;
            if (!ack_now) begin
              state_d = ST_WAIT;
            end
          end else if (scl_fall && in_ack_q) begin
            in_ack_d = 1'b0;
            cnt_d = 4'h0;
            oe_d = 1'b0;
            if (state_q == ST_DEV && rnw_q) begin
              state_d = ST_RDATA;
              shreg_d = mem_q[ptr_q];
              oe_d = ~mem_q[ptr_q][7];
              ptr_d = ptr_inc;
            end else if (state_q == ST_DEV) begin
              state_d = ST_WADDR;
            end else begin
              state_d = ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            if (in_ack_q) begin
              mack_d = ~sda_s2;
            end else if (cnt_q < ACK_SLOT) begin
              cnt_d = cnt_q + 4'h1;
            end
          end else if (scl_fall) begin
            if (in_ack_q) begin
              in_ack_d = 1'b0;
              cnt_d = 4'h0;
              if (mack_q) begin
                shreg_d = mem_q[ptr_q];
                oe_d = ~mem_q[ptr_q][7];
                ptr_d = ptr_inc;
              end else begin
                state_d = ST_WAIT;
                oe_d = 1'b0;
              end
            end else if (cnt_q == ACK_SLOT) begin
              oe_d = 1'b0;  // Release for the master's acknowledge
              in_ack_d = 1'b1;
            end else if (cnt_q != 4'h0 && cnt_q <= LAST_BIT) begin
              shreg_d = {shreg_q[6:0], 1'b0};
              oe_d = ~shreg_q[6];
            end
          end
        end
        ST_WAIT: begin
          oe_d = 1'b0;
        end
        ST_IDLE: begin
          oe_d = 1'b0;
        end
        default: begin
          state_d = ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // Serial engine registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      in_ack_q <= 1'b0;
      oe_q <= 1'b0;
      rnw_q <= 1'b0;
      mack_q <= 1'b0;
      wrote_q <= 1'b0;
      shreg_q <= 8'h00;
      dev_q <= 3'h0;
      ptr_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      in_ack_q <= in_ack_d;
      oe_q <= oe_d;
      rnw_q <= rnw_d;
      mack_q <= mack_d;
      wrote_q <= wrote_d;
      shreg_q <= shreg_d;
      dev_q <= dev_d;
      ptr_q <= ptr_d;
    end
  end

  // ****************************************
  // Internal write cycle timer
  // ****************************************
  // Busy starts on the stop that ends a write with data
  always_comb begin
    busy_d = busy_q;
    timer_d = timer_q;
    if (!busy_q) begin
      if (stop_cond && wrote_q) begin
        busy_d = 1'b1;
        timer_d = 32'h0;
      end
    end else if (timer_q >= 32'(WRITE_CYCLES - 1) && !fifo_out_valid) begin
      busy_d = 1'b0;
    end else begin
      timer_d = timer_q + 32'h1;
    end
  end

  // Timer registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      timer_q <= 32'h0;
    end else begin
      busy_q <= busy_d;
      timer_q <= timer_d;
    end
  end

  // Open-drain output: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe = oe_q;
  assign prog_busy = busy_q;

endmodule

// ---- testbench/serial_eeprom_asserts.sv ----
// Purpose: Pin checks on the two-wire memory slave.
// Assumes: All pins sampled on clk.
// Notes: Bound to the top module.
module serial_eeprom_asserts #(
  parameter int WRITE_CYCLES = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_oe,
  input wire logic wp_i,
  input wire logic prog_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int bc_q;
  int bc_d;
  int hc_q;
  int hc_d;
  // Count busy cycles and link clock high cycles
  always_comb begin
    bc_d = prog_busy ? bc_q + 1 : 0;
    hc_d = scl_i ? hc_q + 1 : 0;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bc_q <= 0;
      hc_q <= 0;
    end else begin
      bc_q <= bc_d;
      hc_q <= hc_d;
    end
  end
  // ********
  // Properties
  // ********
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_oe_low;
    $changed(sda_oe) |-> !$past(scl_i, 2);
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("drive moved");
  property p_busy_nack;
    prog_busy |-> !sda_oe;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("busy drive");
  property p_busy_min;
    $fell(prog_busy) |-> bc_q >= WRITE_CYCLES;
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy short");
  property p_busy_max;
    prog_busy |-> bc_q < WRITE_CYCLES + 100;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy long");
  property p_stop_prog;
    $rose(prog_busy) |-> scl_i && !$past(sda_i, 6);
  endproperty
  a_stop_prog: assert property (p_stop_prog) else $error("busy no stop");
  property p_lock;
    wp_i && $past(wp_i, 4) |-> !$rose(prog_busy);
  endproperty
  a_lock: assert property (p_lock) else $error("locked prog");
  property p_ack_len;
    $rose(sda_oe) |=> sda_oe [*6];
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("drive short");
  property p_idle;
    hc_q > 9 |-> !sda_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("idle drive");
endmodule
bind serial_eeprom serial_eeprom_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .scl_i(scl_i), .sda_i(sda_i), .sda_oe(sda_oe),
  .wp_i(wp_i), .prog_busy(prog_busy)
);

// ---- testbench/i2c_master_model.sv ----
// Purpose: Two-wire bus master model.
// Assumes: Pull-up on data; 80 ns link clock.
// Notes: Clock stands high between frames.
module i2c_master_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One bit: drive b while low, sample the wire mid high
  task automatic bit_x(input logic b, output logic r);
    hc(1);
    sda_m <= b;
    hc(3);
    scl <= 1'b1;
    hc(2);
    #1 r = sda;
    hc(2);
    scl <= 1'b0;
  endtask
  // Start or repeated start
  task automatic start();
    hc(1);
    sda_m <= 1'b1;
    hc(3);
    scl <= 1'b1;
    hc(4);
    sda_m <= 1'b0;
    hc(4);
    scl <= 1'b0;
  endtask
  task automatic stop();
    hc(1);
    sda_m <= 1'b0;
    hc(3);
    scl <= 1'b1;
    hc(4);
    sda_m <= 1'b1;
    hc(4);
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(v[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  // Master acknowledge asks for more, release ends the read
  task automatic rbyte(input logic mack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
    bit_x(!mack, r);
  endtask
endmodule

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the two-wire memory slave.
// Assumes: 256-byte and 128-byte devices share the wires; write time cut to 150 clocks.
// Notes: Array model is compared at every read; acks are checked except the device byte of a fresh dummy write.
module testbench
  import eeprom_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wp, scl, sda_m, sda_oe, sda_oe_s, sda_o, sda_o_s, prog_busy, k, alt;
  logic [2:0] a;
  logic [7:0] d;
  logic [7:0] mem [256];
  int miscompares, check_count, seed, i;
  // Open-drain wire: a driving device shows its output value, pull-up otherwise
  wire sda = sda_m & (sda_oe ? sda_o : 1'b1) & (sda_oe_s ? sda_o_s : 1'b1);
  serial_eeprom #(.ADDR_W(8), .WRITE_CYCLES(150)) uut (
    .clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .wp_i(wp), .a_i(a), .prog_busy(prog_busy)
  );
  // Smallest density on the same wires, select value differs in its low bit
  serial_eeprom #(.ADDR_W(7), .WRITE_CYCLES(150)) uut_small (
    .clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o_s),
    .sda_oe(sda_oe_s), .wp_i(wp), .a_i(a ^ 3'h1), .prog_busy()
  );
  i2c_master_model m (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [7:0] dv(input logic rw);
    return {DEV_TYPE_CODE, a ^ {2'b00, alt}, rw};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // Poll until the address is acknowledged
  task automatic poll();
    int n;
    n = 0;
    k = 1'b0;
    while (!k && n < 20) begin
      m.start();
      m.wbyte(dv(1'b0), k);
      n++;
    end
    chk(8'(n > 1), 8'h1);
    chk(8'(k), 8'h1);
  endtask
  // Byte address then n bytes, of which lim are taken
  task automatic wr(input logic [7:0] ad, input int n, input int lim);
    m.wbyte(ad, k);
    chk(8'(k), 8'h1);
    for (int j = 0; j < n; j++) begin
      d = 8'($random(seed));
      m.wbyte(d, k);
      chk(8'(k), 8'(j < lim));
      if (j < lim) mem[8'(ad + j)] = d;
    end
    m.stop();
  endtask
  // Dummy write, repeated start, then n bytes
  task automatic rd(input logic [7:0] ad, input int n, input bit fresh);
    if (fresh) begin
      m.start();
      m.wbyte(dv(1'b0), k);
    end
    m.wbyte(ad, k);
    chk(8'(k), 8'h1);
    m.start();
    m.wbyte(dv(1'b1), k);
    chk(8'(k), 8'h1);
    for (int j = 0; j < n; j++) begin
      m.rbyte(j < n - 1, d);
      chk(d, mem[(alt && ad + j > 127) ? 8'h7f : 8'(ad + j)]);
    end
    m.stop();
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    conclude();
  end
  // Main sequence
  initial begin
    seed = 32;
    miscompares = 0;
    check_count = 0;
    rst = 1'b1;
    wp = 1'b0;
    alt = 1'b0;
    a = 3'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    a <= 3'($random(seed));
    repeat (4) @(posedge clk);
    // Fill the page buffer until it refuses
    m.start();
    m.wbyte(dv(1'b0), k);
    chk(8'(k), 8'h1);
    wr(8'hf0, 17, 16);
    poll();
    wr(8'h00, 2, 2);
    poll();
    rd(8'hfe, 3, 1'b0);
    // Read at the counter
    m.start();
    m.wbyte(dv(1'b1), k);
    chk(8'(k), 8'h1);
    m.rbyte(1'b0, d);
    chk(d, mem[1]);
    m.stop();
    // Locked array
    wp <= 1'b1;
    m.start();
    m.wbyte(dv(1'b0), k);
    chk(8'(k), 8'h1);
    wr(8'h00, 1, 0);
    repeat (19) @(posedge clk);
    @(negedge clk);
    chk(8'(prog_busy), 8'h0);
    @(posedge clk);
    wp <= 1'b0;
    rd(8'h00, 1, 1'b1);
    // Smallest density: reading past the top repeats the top location
    alt = 1'b1;
    m.start();
    m.wbyte(dv(1'b0), k);
    chk(8'(k), 8'h1);
    wr(8'h7f, 1, 1);
    poll();
    rd(8'h7f, 2, 1'b0);
    alt = 1'b0;
    // Every type code and select value
    for (i = 0; i < 128; i++) begin
      m.start();
      m.wbyte({i[6:0], 1'b0}, k);
      chk(8'(k), 8'(i[6:0] == {DEV_TYPE_CODE, a} ||
                    i[6:0] == {DEV_TYPE_CODE, a ^ 3'h1}));
      m.stop();
    end
    conclude();
  end
endmodule
